// ==== spd_phase_ctrl.v ====
// Phase delay control of a line-locked clock generator, Wishbone slave
//
// Overview of operation
// RL1 - Delay equals period times selected over total
// RL2 - Resolution code selects 16, 32, 64 elements
// RL3 - Software keeps selected count within resolution
// RL4 - Software matches resolution to clock rate
// RL5 - Above 160 MHz software clears delay enable
// RL6 - Resolution loads only on reset command 0xA
// RL7 - Control bit 2 picks rising or falling
// RL8 - Half-rate clock fixed phase at sync fall
// RL9 - Negative half-rate output complements positive
// RL10 - Registers return to defaults at power-up
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "spd_defines.vh"

module spd_phase_ctrl
(
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [9:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // Sync input and measured clock period in system clocks
  input  wire        hsync_i,
  input  wire [15:0] clk_period_i,
  // Clock outputs
  output wire        regenerated_sync_output_o,
  output reg         half_clk_p_o,
  output wire        half_clk_n_o
);

  // Control registers
  reg [7:0] ctrl_q;
  reg [7:0] delay_q;
  reg [1:0] res_shadow_q;
  reg [1:0] res_work_q;

  // Sync synchroniser and edge detection
  reg       hs_meta_q;
  reg       hs_sync_q;
  reg       hs_prev_q;
  reg       out_prev_q;

  wire      req      = cyc_i & stb_i;
  // Writes land at the edge where the master samples ack high
  wire      wr_go    = req & we_i & ack_o;
  wire      edge_sel = ctrl_q[`SPD_CTRL_EDGE];

  // Total elements for a resolution code, as a shift amount
  function [2:0] res_shift;
    input [1:0] code;
    begin
      case (code)
        `SPD_RES_16: res_shift = 3'd4; // RL2
        `SPD_RES_32: res_shift = 3'd5; // RL2
        `SPD_RES_64: res_shift = 3'd6; // RL2
        default:     res_shift = 3'd4;
      endcase
    end
  endfunction

  // Selected count masked to the resolution; software keeps it in range,
  // masking only protects against a stray high bit
  function [5:0] sel_mask;
    input [1:0] code;
    input [5:0] cnt;
    begin
      case (code)
        `SPD_RES_32: sel_mask = cnt & 6'h1f;
        `SPD_RES_64: sel_mask = cnt & 6'h3f;
        default:     sel_mask = cnt & 6'h0f;
      endcase
    end
  endfunction

  // Offset = period * selected / total, in system clock cycles
  wire [5:0]  sel_cnt = sel_mask(res_work_q, delay_q[5:0]);
  wire [21:0] prod    = clk_period_i * sel_cnt; // RL1
  wire [21:0] shifted = prod >> res_shift(res_work_q); // RL1
  wire [15:0] delay_cycles = shifted[15:0];
  wire        delay_en = delay_q[`SPD_DELAY_EN]; // RL5

  // Register writes; power-up defaults via reset
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q       <= `SPD_CTRL_RST; // RL10
      delay_q      <= `SPD_DELAY_RST; // RL10
      res_shadow_q <= `SPD_RES_RST; // RL10
      res_work_q   <= `SPD_RES_RST; // RL10
    end
    else if (wr_go && sel_i[0])
    begin
      case (adr_i)
        `SPD_ADDR_CTRL:  ctrl_q       <= dat_i[7:0];
        `SPD_ADDR_DELAY: delay_q      <= dat_i[7:0];
        `SPD_ADDR_RES:   res_shadow_q <= dat_i[1:0];
        `SPD_ADDR_RESET:
        begin
          if (dat_i[3:0] == `SPD_RESET_CMD)
            res_work_q <= res_shadow_q; // RL6
        end
        default: ;
      endcase
    end
  end

  // Wishbone answer: one wait state, unmapped reads return zero
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= req & ~ack_o;
      dat_o <= 32'h0000_0000;
      if (req && !we_i && !ack_o)
      begin
        case (adr_i)
          `SPD_ADDR_CTRL:   dat_o <= {24'h00_0000, ctrl_q};
          `SPD_ADDR_DELAY:  dat_o <= {24'h00_0000, delay_q};
          `SPD_ADDR_RES:    dat_o <= {30'h0000_0000, res_shadow_q};
          `SPD_ADDR_STATUS:
            dat_o <= {28'h000_0000, res_work_q,
                      regenerated_sync_output_o, half_clk_p_o};
          default:          dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Two-stage synchroniser for the external sync pin
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hs_meta_q <= 1'b0;
      hs_sync_q <= 1'b0;
      hs_prev_q <= 1'b0;
    end
    else
    begin
      hs_meta_q <= hsync_i;
      hs_sync_q <= hs_meta_q;
      hs_prev_q <= hs_sync_q;
    end
  end

  // Edge polarity: the reference edge starts the pulse
  wire hs_edge  = hs_sync_q ^ hs_prev_q;
  wire hs_level = hs_sync_q ^ edge_sel; // RL7

  spd_delay_line u_delay
  (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .enable_i       (delay_en),
    .delay_cycles_i (delay_cycles),
    .sync_edge_i    (hs_edge),
    .sync_level_i   (hs_level),
    .sync_out_o     (regenerated_sync_output_o)
  );

  // Half-rate clock toggles freely but is forced to a known phase at
  // the fall of the regenerated sync, so odd feedback divides match even
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_prev_q   <= 1'b0;
      half_clk_p_o <= 1'b0;
    end
    else
    begin
      out_prev_q <= regenerated_sync_output_o;
      if (out_prev_q && !regenerated_sync_output_o)
        half_clk_p_o <= 1'b0; // RL8
      else
        half_clk_p_o <= ~half_clk_p_o;
    end
  end

  assign half_clk_n_o = ~half_clk_p_o; // RL9

endmodule // spd_phase_ctrl

`default_nettype wire

// ==== spd_defines.vh ====
// Register map, field positions and reset values of the phase delay control
`ifndef SPD_DEFINES_VH
`define SPD_DEFINES_VH

// Register byte offsets (register index times four)
`define SPD_IDX_CTRL      8'h00
`define SPD_IDX_DELAY     8'h04
`define SPD_IDX_RES       8'h05
`define SPD_IDX_RESET     8'h08
`define SPD_IDX_STATUS    8'h09
`define SPD_ADDR_CTRL     10'h000
`define SPD_ADDR_DELAY    10'h010
`define SPD_ADDR_RES      10'h014
`define SPD_ADDR_RESET    10'h020
`define SPD_ADDR_STATUS   10'h024

// Field positions
`define SPD_CTRL_EDGE     2
`define SPD_DELAY_EN      7
`define SPD_STAT_HALF     0
`define SPD_STAT_SYNC     1
`define SPD_STAT_RES_LO   2

// Reset values
`define SPD_CTRL_RST      8'h00
`define SPD_DELAY_RST     8'h00
`define SPD_RES_RST       2'h0

// Resolution codes and the reset command nibble
`define SPD_RES_16        2'h0
`define SPD_RES_32        2'h1
`define SPD_RES_64        2'h3
`define SPD_RESET_CMD     4'ha

// Phase accumulator width: one clock period spans up to 64 fine steps
`define SPD_PHASE_W       6
`define SPD_PERIOD_W      16

`endif

// ==== spd_delay_line.v ====
// Digital model of the tapped delay line: delays a sync edge by a phase
`timescale 1ns/1ps
`default_nettype none
`include "spd_defines.vh"

module spd_delay_line
(
  // Clock and reset
  input  wire                     clk_i,
  input  wire                     rst_i,
  // Control
  input  wire                     enable_i,
  input  wire [`SPD_PERIOD_W-1:0] delay_cycles_i,
  input  wire                     sync_edge_i,
  input  wire                     sync_level_i,
  // Output
  output reg                      sync_out_o
);

  reg [`SPD_PERIOD_W-1:0] cnt_q;
  reg                     busy_q;
  reg                     level_q;

  // Only one edge in flight; a new edge restarts the count, which is
  // acceptable since sync periods exceed any programmed delay
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q      <= {`SPD_PERIOD_W{1'b0}};
      busy_q     <= 1'b0;
      level_q    <= 1'b0;
      sync_out_o <= 1'b0;
    end
    else if (sync_edge_i)
    begin
      if (!enable_i || delay_cycles_i == {`SPD_PERIOD_W{1'b0}})
      begin
        sync_out_o <= sync_level_i;
        busy_q     <= 1'b0;
      end
      else
      begin
        cnt_q   <= delay_cycles_i;
        level_q <= sync_level_i;
        busy_q  <= 1'b1;
      end
    end
    else if (busy_q)
    begin
      if (cnt_q == {{(`SPD_PERIOD_W-1){1'b0}}, 1'b1})
      begin
        sync_out_o <= level_q;
        busy_q     <= 1'b0;
      end
      cnt_q <= cnt_q - {{(`SPD_PERIOD_W-1){1'b0}}, 1'b1};
    end
  end

endmodule // spd_delay_line

`default_nettype wire

// ==== spd_hsync_src.sv ====
// Horizontal sync source model driving the sync pin
`timescale 1ns/1ps
`default_nettype none
module spd_hsync_src (
  input  wire logic clk_i,
  input  wire logic lvl_i,
  output var  logic hsync_o
);
  // Registered so the pin moves only just after a clock edge
  initial hsync_o = 1'b0;
  always @(posedge clk_i) hsync_o <= lvl_i;
endmodule // spd_hsync_src
`default_nettype wire

// ==== spd_phase_ctrl_checker.sv ====
// Port assertions of the phase delay control
`timescale 1ns/1ps
`default_nettype none
module spd_phase_ctrl_checker (
  input wire        clk_i, rst_i, cyc_i, stb_i, ack_o,
  input wire        regenerated_sync_output_o, half_clk_p_o, half_clk_n_o,
  input wire [31:0] dat_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_half_comp: assert property (half_clk_n_o == ~half_clk_p_o)
    else $error("half-rate pair not complementary");
  a_half_fall: assert property ($fell(regenerated_sync_output_o)
    |=> !half_clk_p_o) else $error("half clock phase wrong at fall");
  // Reset must hold outputs even though other checks are off then
  a_reset_out: assert property (disable iff (1'b0) rst_i |=> !ack_o
    && dat_o == 32'h0 && !half_clk_p_o) else $error("outputs not reset");
  a_ack_resp: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_spur: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  a_dat_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule // spd_phase_ctrl_checker
`default_nettype wire

// ==== spd_phase_ctrl_tb.sv ====
// Self-checking bench of the phase delay control
`timescale 1ns/1ps
`default_nettype none
module spd_phase_ctrl_tb;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, lvl = 0;
  logic [9:0]  adr = 10'h0;
  logic [31:0] dat = 32'h0, q;
  logic [15:0] per = 16'h0010;
  logic [1:0]  code, prev;
  wire         hs, rso, hp, hn, ack;
  wire  [31:0] dato;
  integer      mismatches = 0, n_tests = 0, cyc_n = 0, n0, n, s, sh;
  int unsigned rs = 45;
  always #10 clk_i = ~clk_i;
  spd_hsync_src u_spd_hsync_src (.clk_i(clk_i), .lvl_i(lvl), .hsync_o(hs));
  spd_phase_ctrl u_spd_phase_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf),
    .dat_i(dat), .dat_o(dato), .ack_o(ack), .hsync_i(hs),
    .clk_period_i(per), .regenerated_sync_output_o(rso),
    .half_clk_p_o(hp), .half_clk_n_o(hn));
  function int unsigned xs();
    rs ^= rs << 13; rs ^= rs >> 17; rs ^= rs << 5;
    return rs;
  endfunction
  task close_out;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      mismatches++;
      close_out;
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task wb(input logic w, input logic [9:0] a, input logic [31:0] v);
    integer t;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= v;
    t = 0;
    do @(posedge clk_i); while (ack !== 1'b1 && ++t < 20);
    if (t == 20)
    begin
      mismatches++;
      close_out;
    end
    q = dato;
    cyc <= 0; stb <= 0;
  endtask
  // Sync stays high until the output follows, so no edge is lost
  task pulse(output integer c);
    integer t;
    c = 0; t = 0;
    lvl <= 1;
    do begin @(posedge clk_i); c++; end while (rso !== 1'b1 && c < 300);
    lvl <= 0;
    do begin @(posedge clk_i); t++; end while (rso !== 1'b0 && t < 300);
    @(posedge clk_i);
    chk("half phase", 0, hp);
    chk("half pair", 1, hp ^ hn);
  endtask
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    for (int r = 0; r < 2; r++)
    begin
      wb(0, 10'h000, 0); chk("ctrl", 0, q);
      wb(0, 10'h010, 0); chk("delay", 0, q);
      wb(0, 10'h014, 0); chk("res", 0, q);
      wb(0, 10'h024, 0); chk("res work", 0, {30'h0, q[3:2]});
      wb(0, 10'h3fc, 0); chk("unmapped", 0, q);
      if (r == 0)
      begin
        $display("test defaults done");
        pulse(n0); chk("base delay", 5, n0);
        prev = 2'h0;
        for (int i = 0; i < 3; i++)
        begin
          code = (i == 2) ? 2'h3 : 2'(i);
          wb(1, 10'h014, {30'h0, code}); wb(1, 10'h020, 32'h5);
          wb(0, 10'h024, 0); chk("res hold", prev, {30'h0, q[3:2]});
          wb(1, 10'h020, 32'ha);
          wb(0, 10'h024, 0); chk("res load", code, {30'h0, q[3:2]});
          prev = code;
          sh = 4 + i;
          s = xs() & ((1 << sh) - 1);
          per <= 16'(8 + xs() % 64);
          wb(1, 10'h010, 32'h80 | s); pulse(n);
          chk("delay", n0 + ((per * s) >> sh), n);
        end
        wb(1, 10'h010, 32'h3f); pulse(n); chk("bypass", n0, n);
        $display("test delay done");
        wb(1, 10'h010, 0); wb(1, 10'h000, 32'h4);
        lvl <= 1;
        repeat (8) @(posedge clk_i); chk("fall sel rise", 0, rso);
        lvl <= 0;
        repeat (8) @(posedge clk_i); chk("fall edge", 1, rso);
        wb(1, 10'h000, 0);
        lvl <= 1;
        repeat (8) @(posedge clk_i); chk("rise edge", 1, rso);
        lvl <= 0;
        repeat (8) @(posedge clk_i); chk("rise sel fall", 0, rso);
        wb(1, 10'h010, 32'h85);
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
      end
    end
    $display("test reset done");
    close_out;
  end
endmodule // spd_phase_ctrl_tb
bind spd_phase_ctrl spd_phase_ctrl_checker u_chk (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .regenerated_sync_output_o(regenerated_sync_output_o),
  .half_clk_p_o(half_clk_p_o), .half_clk_n_o(half_clk_n_o), .dat_o(dat_o));
`default_nettype wire
